/* pkg/and_imm_branch_pkg.sv */
// Constants, field layouts and carrier types for the and-immediate and branch executor
package and_imm_branch_pkg;

  localparam int XLEN = 32;
  localparam int REG_IDX_W = 5;
  localparam int OPCODE_W = 6;
  localparam int SUBOP_W = 4;
  localparam int IMM_FIELD_16_W = 16;
  localparam int OFF_W = 12;

  // Field positions inside the instruction word
  localparam int OPCODE_LSB = 26;
  localparam int FIELD_A_LSB = 21;
  localparam int FIELD_B_LSB = 16;
  localparam int SUBOP_LSB = 12;
  localparam int IMM_FIELD_16_LSB = 0;
  localparam int OFF_LSB = 0;

  // Encodings
  localparam logic [OPCODE_W-1:0] OPC_AND_IMM = 6'h09;
  localparam logic [OPCODE_W-1:0] OPC_BRANCH = 6'h01;
  localparam logic [SUBOP_W-1:0] SUB_BR_EQ = 4'hc;
  localparam logic [SUBOP_W-1:0] SUB_BR_GE = 4'h9;

  // Immediate upper half, instruction size, word-to-byte shift
  localparam logic [15:0] IMM_UPPER_ZERO = 16'h0000;
  localparam logic [XLEN-1:0] INSN_BYTES = 32'h0000_0004;
  localparam int WORD_SHIFT = 2;

  // Reset values
  localparam logic [XLEN-1:0] RESET_PC = 32'h0000_0000;
  localparam logic [XLEN-1:0] RESET_DATA = 32'h0000_0000;
  localparam logic [REG_IDX_W-1:0] RESET_IDX = 5'h00;

  typedef enum {
    OP_AND_IMM,
    OP_BR_EQ,
    OP_BR_GE,
    OP_ILLEGAL
  } op_kind_type;

  // Request from issue stage: instruction, its address and read operands
  typedef struct packed {
    logic valid;
    logic [XLEN-1:0] insn;
    logic [XLEN-1:0] pc;
    logic [XLEN-1:0] opnd_a;
    logic [XLEN-1:0] opnd_b;
  } issue_type;

  // Retired answer one cycle later
  typedef struct packed {
    logic done;
    logic illegal;
    logic wr_en;
    logic [REG_IDX_W-1:0] wr_idx;
    logic [XLEN-1:0] wr_data;
    logic taken;
    logic [XLEN-1:0] next_pc;
  } retire_type;

endpackage : and_imm_branch_pkg

/* logic/and_imm_branch_exec.sv */
// Decode and single-cycle execute of and-immediate, branch-equal, branch-greater-equal
`timescale 1ns/1ns
module and_imm_branch_exec
  import and_imm_branch_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Issue side
  input wire issue_type issue,
  // Field indices, registered from the last valid issue
  output logic [REG_IDX_W-1:0] idx_a_ff,
  output logic [REG_IDX_W-1:0] idx_b_ff,
  // Retire side
  output retire_type retire_ff
);

  function automatic logic [XLEN-1:0] plus_four(input logic [XLEN-1:0] addr);
    plus_four = addr + INSN_BYTES;
  endfunction : plus_four

  function automatic logic [XLEN-1:0] branch_target(
    input logic [XLEN-1:0] addr,
    input logic [OFF_W-1:0] off
  );
    logic [XLEN-1:0] disp;
    disp = {{(XLEN-OFF_W){off[OFF_W-1]}}, off} << WORD_SHIFT;
    branch_target = plus_four(addr) + disp;
  endfunction : branch_target

  logic [OPCODE_W-1:0] opcode;
  logic [SUBOP_W-1:0] subop;
  logic [REG_IDX_W-1:0] field_a;
  logic [REG_IDX_W-1:0] field_b;
  logic [IMM_FIELD_16_W-1:0] imm_field_16;
  logic [OFF_W-1:0] branch_offset_field;
  logic [XLEN-1:0] operand_a_reg;
  logic [XLEN-1:0] operand_b_reg;
  logic [XLEN-1:0] imm_zext;
  op_kind_type op_kind;
  logic cond_true;
  retire_type nxt_retire;

  assign opcode = issue.insn[OPCODE_LSB +: OPCODE_W];
  assign subop = issue.insn[SUBOP_LSB +: SUBOP_W];
  assign branch_offset_field = issue.insn[OFF_LSB +: OFF_W];
  assign field_a = issue.insn[FIELD_A_LSB +: REG_IDX_W];
  assign field_b = issue.insn[FIELD_B_LSB +: REG_IDX_W];
  assign imm_field_16 = issue.insn[IMM_FIELD_16_LSB +: IMM_FIELD_16_W];
  assign operand_a_reg = issue.opnd_a;
  assign operand_b_reg = issue.opnd_b;
  assign imm_zext = {IMM_UPPER_ZERO, imm_field_16};

  always_comb
  begin
    op_kind = OP_ILLEGAL;
    if (opcode == OPC_AND_IMM)
    begin
      op_kind = OP_AND_IMM;
    end
    else if (opcode == OPC_BRANCH && subop == SUB_BR_EQ)
    begin
      op_kind = OP_BR_EQ;
    end
    else if (opcode == OPC_BRANCH && subop == SUB_BR_GE)
    begin
      op_kind = OP_BR_GE;
    end
  end

  always_comb
  begin
    cond_true = 1'b0;
    unique case (op_kind)
      OP_BR_EQ: cond_true = (operand_a_reg == operand_b_reg);
      OP_BR_GE: cond_true = ($signed(operand_a_reg) >= $signed(operand_b_reg));
      OP_AND_IMM: cond_true = 1'b0;
      OP_ILLEGAL: cond_true = 1'b0;
    endcase
  end

  always_comb
  begin
    nxt_retire = '0;
    nxt_retire.done = issue.valid;
    nxt_retire.wr_idx = field_b;
    nxt_retire.next_pc = plus_four(issue.pc);
    if (issue.valid)
    begin
      unique case (op_kind)
        OP_AND_IMM:
        begin
          nxt_retire.wr_en = 1'b1;
          nxt_retire.wr_data = operand_a_reg & imm_zext;
        end
        OP_BR_EQ, OP_BR_GE:
        begin
          nxt_retire.taken = cond_true;
          if (cond_true)
          begin
            nxt_retire.next_pc = branch_target(issue.pc, branch_offset_field);
          end
        end
        OP_ILLEGAL: nxt_retire.illegal = 1'b1;
      endcase
    end
  end

  // Result register, one cycle after issue
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      retire_ff <= '{done: 1'b0, illegal: 1'b0, wr_en: 1'b0, wr_idx: RESET_IDX,
                     wr_data: RESET_DATA, taken: 1'b0, next_pc: RESET_PC};
    end
    else
    begin
      retire_ff <= nxt_retire;
    end
  end

  // Indices latch with the retire word on a valid issue only, and hold otherwise, for writeback bookkeeping
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      idx_a_ff <= RESET_IDX;
      idx_b_ff <= RESET_IDX;
    end
    else if (issue.valid)
    begin
      idx_a_ff <= field_a;
      idx_b_ff <= field_b;
    end
  end

  // Checks on the retire word against the issued request
  property p_and_result;
    @(posedge clk) disable iff (rst)
    (issue.valid && opcode == OPC_AND_IMM) |=>
      (retire_ff.wr_en && retire_ff.wr_data[31:16] == 16'h0000
       && retire_ff.wr_data[15:0] == ($past(issue.opnd_a[15:0]) & $past(issue.insn[15:0])));
  endproperty
  a_and_result: assert property (p_and_result) else $error("and-immediate result wrong");

  property p_no_sign_ext;
    @(posedge clk) disable iff (rst)
    (issue.valid && opcode == OPC_AND_IMM && issue.insn[15] && issue.opnd_a == 32'hffff_ffff)
      |=> retire_ff.wr_data == {16'h0000, $past(issue.insn[15:0])};
  endproperty
  a_no_sign_ext: assert property (p_no_sign_ext) else $error("immediate was sign-extended");

  property p_dest_b;
    @(posedge clk) disable iff (rst)
    issue.valid |=> (retire_ff.wr_idx == $past(issue.insn[20:16])
                     && idx_a_ff == $past(issue.insn[25:21]));
  endproperty
  a_dest_b: assert property (p_dest_b) else $error("register field decode wrong");

  property p_beq;
    @(posedge clk) disable iff (rst)
    (issue.valid && op_kind == OP_BR_EQ) |=>
      retire_ff.taken == ($past(issue.opnd_a) == $past(issue.opnd_b));
  endproperty
  a_beq: assert property (p_beq) else $error("branch-equal decision wrong");

  property p_bge;
    @(posedge clk) disable iff (rst)
    (issue.valid && op_kind == OP_BR_GE && issue.opnd_a[31] && !issue.opnd_b[31])
      |=> !retire_ff.taken;
  endproperty
  a_bge: assert property (p_bge) else $error("negative operand taken as greater");

  property p_target;
    @(posedge clk) disable iff (rst)
    (issue.valid && opcode == OPC_BRANCH && cond_true) |=>
      retire_ff.next_pc == $past(issue.pc) + 32'h4
        + {{18{$past(issue.insn[11])}}, $past(issue.insn[11:0]), 2'b00};
  endproperty
  a_target: assert property (p_target) else $error("branch target wrong");

  property p_reach;
    @(posedge clk) disable iff (rst)
    retire_ff.taken |->
      ($signed(retire_ff.next_pc - $past(issue.pc) - 32'h4) >= -32'sd8192
       && $signed(retire_ff.next_pc - $past(issue.pc) - 32'h4) <= 32'sd8188
       && retire_ff.next_pc[1:0] == $past(issue.pc[1:0]));
  endproperty
  a_reach: assert property (p_reach) else $error("branch reach exceeded");

  property p_seq;
    @(posedge clk) disable iff (rst)
    (issue.valid && !(opcode == OPC_BRANCH && cond_true)) |=>
      (!retire_ff.taken && retire_ff.next_pc == $past(issue.pc) + 32'h4);
  endproperty
  a_seq: assert property (p_seq) else $error("sequential address wrong");

  property p_decode;
    @(posedge clk) disable iff (rst)
    (issue.valid && issue.insn[31:26] == 6'h01 && issue.insn[15:12] != 4'hc
     && issue.insn[15:12] != 4'h9) |=> (retire_ff.illegal && !retire_ff.taken);
  endproperty
  a_decode: assert property (p_decode) else $error("unknown sub-opcode accepted");

  c_and: cover property (@(posedge clk) disable iff (rst)
    issue.valid && op_kind == OP_AND_IMM);
  c_beq_taken: cover property (@(posedge clk) disable iff (rst)
    issue.valid && op_kind == OP_BR_EQ && cond_true);
  c_bge_back: cover property (@(posedge clk) disable iff (rst)
    issue.valid && op_kind == OP_BR_GE && cond_true && branch_offset_field[11]);
  c_bge_not: cover property (@(posedge clk) disable iff (rst)
    issue.valid && op_kind == OP_BR_GE && !cond_true);

endmodule : and_imm_branch_exec

/* testbench/and_imm_branch_exec_tb.sv */
// Self-checking bench for the and-immediate and branch executor
`timescale 1ns/1ns
module and_imm_branch_exec_tb;
  import and_imm_branch_pkg::*;
  logic clk;
  logic rst;
  issue_type issue;
  logic [REG_IDX_W-1:0] idx_a_ff;
  logic [REG_IDX_W-1:0] idx_b_ff;
  retire_type retire_ff;
  int error_cnt;
  int check_count;
  logic [XLEN-1:0] a_val;
  logic [XLEN-1:0] b_val;

  and_imm_branch_exec dut
  (
    .clk(clk),
    .rst(rst),
    .issue(issue),
    .idx_a_ff(idx_a_ff),
    .idx_b_ff(idx_b_ff),
    .retire_ff(retire_ff)
  );

  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // Reference result, built straight from the field layout
  function automatic retire_type expect_of(issue_type i);
    retire_type r;
    logic [OPCODE_W-1:0] op;
    logic [SUBOP_W-1:0] sub;
    r = '0;
    op = i.insn[31:26];
    sub = i.insn[15:12];
    r.done = 1'b1;
    r.wr_idx = i.insn[20:16];
    r.next_pc = i.pc + 32'h0000_0004;
    if (op == OPC_AND_IMM)
    begin
      r.wr_en = 1'b1;
      r.wr_data = i.opnd_a & {16'h0000, i.insn[15:0]};
    end
    else if (op == OPC_BRANCH && sub == SUB_BR_EQ)
      r.taken = (i.opnd_a == i.opnd_b);
    else if (op == OPC_BRANCH && sub == SUB_BR_GE)
      r.taken = ($signed(i.opnd_a) >= $signed(i.opnd_b));
    else
      r.illegal = 1'b1;
    if (r.taken)
      r.next_pc = r.next_pc + {{18{i.insn[11]}}, i.insn[11:0], 2'b00};
    return r;
  endfunction : expect_of

  function automatic logic [XLEN-1:0] mk(logic [5:0] op, logic [15:0] low);
    return {op, 5'($urandom), 5'($urandom), low};
  endfunction : mk

  task automatic end_of_test();
    if (error_cnt == 0 && check_count > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : end_of_test

  task automatic chk(logic [127:0] got, logic [127:0] exp);
    check_count++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  // Entered at a falling edge; leaves the request up so calls run back to back
  task automatic run_one(logic [XLEN-1:0] insn, logic [XLEN-1:0] pc,
                         logic [XLEN-1:0] a, logic [XLEN-1:0] b);
    issue_type cur;
    cur = '{1'b1, insn, pc, a, b};
    issue <= cur;
    @(negedge clk);
    chk(128'(retire_ff), 128'(expect_of(cur)));
    chk(128'({idx_a_ff, idx_b_ff}), 128'(insn[25:16]));
  endtask : run_one

  initial
  begin
    int kind;
    void'($urandom(32'hba1ff64f));
    rst = 1'b1;
    issue = '0;
    error_cnt = 0;
    check_count = 0;
    repeat (2) @(negedge clk);
    rst <= 1'b0;
    @(negedge clk);
    // Upper immediate half must stay clear
    run_one(mk(OPC_AND_IMM, 16'hffff), 32'h0000_0040, 32'hffff_ffff, 32'h1);
    run_one(mk(OPC_AND_IMM, 16'h8001), 32'h0000_0044, 32'h8765_c3c1, 32'h2);
    run_one(mk(OPC_BRANCH, {SUB_BR_EQ, 12'h7ff}), 32'h100, 32'h5, 32'h5);
    run_one(mk(OPC_BRANCH, {SUB_BR_EQ, 12'h800}), 32'h200, 32'h8000_0005, 32'h5);
    run_one(mk(OPC_BRANCH, {SUB_BR_EQ, 12'h800}), 32'h0, 32'h7, 32'h7);
    // Signed order differs from unsigned here
    run_one(mk(OPC_BRANCH, {SUB_BR_GE, 12'h010}), 32'h300, 32'h8000_0000, 32'h7fff_ffff);
    run_one(mk(OPC_BRANCH, {SUB_BR_GE, 12'hff0}), 32'h300, 32'h7fff_ffff, 32'h8000_0000);
    run_one(mk(OPC_BRANCH, {SUB_BR_GE, 12'h001}), 32'hffff_fffc, 32'h9, 32'h9);
    run_one(mk(OPC_BRANCH, {4'hd, 12'h004}), 32'h400, 32'h9, 32'h1);
    run_one(mk(6'h3f, 16'h1234), 32'h404, 32'h9, 32'h1);
    repeat (400)
    begin
      kind = $urandom_range(0, 3);
      a_val = $urandom;
      b_val = $urandom_range(0, 1) ? a_val : $urandom;
      case (kind)
        0: run_one(mk(OPC_AND_IMM, 16'($urandom)), $urandom, a_val, b_val);
        1: run_one(mk(OPC_BRANCH, {SUB_BR_EQ, 12'($urandom)}), $urandom, a_val, b_val);
        2: run_one(mk(OPC_BRANCH, {SUB_BR_GE, 12'($urandom)}), $urandom, a_val, b_val);
        default: run_one(mk(6'($urandom_range(10, 63)), 16'($urandom)), $urandom, a_val, b_val);
      endcase
    end
    issue <= '0;
    @(negedge clk);
    end_of_test();
  end

  // Hang guard, well beyond the few hundred cycles the tests need
  initial
  begin
    repeat (20000) @(posedge clk);
    error_cnt++;
    end_of_test();
  end
endmodule : and_imm_branch_exec_tb
